// >>> src/sdc_ctrl.sv
// SerDes configuration bus controller with signal detect and output tap logic
//
// Operation
// - Shadow, mask, write trigger, then serial write
// - Macro select field is one-bit-per-macro mask
// - Write trigger clears itself when done
// - Mask plus read trigger loads shadow from macros
// - Multi-macro read values are ORed together
// - Read trigger clears itself when done
// - One serial bus carries writes and reads
// - Slow macros use own control register
// - Hysteresis off: raw signal detect forwarded
// - Assert only after active for assert time
// - Deassert only after inactive for deassert time
// - Independent transmit and receive data inversion
// - Both idle enables hand buffers to PCS
// - Pre-cursor tap: sign plus four-bit magnitude
// - First post tap: sign plus five-bit magnitude
// - Second post tap: sign plus four-bit magnitude
// - Centre tap is sixty-four minus tap magnitudes
// - Amplitude coefficient is level plus sixty-four
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "sdc_consts.svh"
module sdc_ctrl
#(
  parameter int N_MACRO = 8,
  parameter int DATA_W = 10,
  parameter int CLK_DIV = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [N_MACRO-1:0] fast_sel,
  output logic [N_MACRO-1:0] slow_sel,
  output logic cbus_dir,
  output logic cbus_strobe,
  output logic cbus_sdo,
  input wire logic cbus_sdi,
  input wire logic sigdet_raw,
  output logic pcs_sigdet,
  input wire logic [DATA_W-1:0] tx_data_in,
  output logic [DATA_W-1:0] tx_data_out,
  input wire logic [DATA_W-1:0] rx_data_in,
  output logic [DATA_W-1:0] rx_data_out,
  output logic pcs_buf_ctrl,
  input wire logic pcs_tx_idle,
  input wire logic pcs_rx_idle,
  output logic obuf_idle,
  output logic ibuf_off,
  output logic [6:0] centre_tap_coef,
  output logic centre_tap_neg,
  output logic [6:0] amp_coef
);

  localparam int SIGDET_UNIT_CYC = `SDC_SIGDET_UNIT_NS / `SDC_CLK_NS;
  localparam logic [3:0] IDX_END = 4'(N_MACRO);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] shadow0_q;
  logic [31:0] shadow1_q;
  logic [N_MACRO-1:0] fast_mask_q;
  logic [N_MACRO-1:0] slow_mask_q;
  logic fast_wr_q;
  logic fast_rd_q;
  logic slow_wr_q;
  logic slow_rd_q;
  sdc_pkg::sdc_state_t state_q;
  logic fam_q;
  logic dir_q;
  logic [N_MACRO-1:0] mask_q;
  logic [3:0] idx_q;
  logic [6:0] bit_q;
  logic [7:0] div_q;
  logic [63:0] shift_q;
  logic [63:0] acc_q;
  logic done_now;
  logic fast_busy;
  logic slow_busy;
  logic bit_tick;
  logic sdi_m_q;
  logic sdi_s_q;

  assign fast_busy = fast_wr_q | fast_rd_q;
  assign slow_busy = slow_wr_q | slow_rd_q;
  assign done_now = (state_q == sdc_pkg::SDC_DONE);
  assign bit_tick = (state_q == sdc_pkg::SDC_SHIFT) && (div_q == 8'(CLK_DIV - 1));

  // Control words: mask and triggers, locked while a transfer is pending
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      fast_mask_q <= '0;
      fast_wr_q <= 1'b0;
      fast_rd_q <= 1'b0;
    end
    else if (done_now && !fam_q)
    begin
      fast_wr_q <= 1'b0;
      fast_rd_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == `SDC_FAST_CTRL_ADDR && !fast_busy)
    begin
      fast_mask_q <= reg_wdata[N_MACRO-1:0];
      fast_wr_q <= reg_wdata[`SDC_WR_TRIG_BIT];
      fast_rd_q <= reg_wdata[`SDC_RD_TRIG_BIT] & ~reg_wdata[`SDC_WR_TRIG_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      slow_mask_q <= '0;
      slow_wr_q <= 1'b0;
      slow_rd_q <= 1'b0;
    end
    else if (done_now && fam_q)
    begin
      slow_wr_q <= 1'b0;
      slow_rd_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == `SDC_SLOW_CTRL_ADDR && !slow_busy)
    begin
      slow_mask_q <= reg_wdata[N_MACRO-1:0];
      slow_wr_q <= reg_wdata[`SDC_WR_TRIG_BIT];
      slow_rd_q <= reg_wdata[`SDC_RD_TRIG_BIT] & ~reg_wdata[`SDC_WR_TRIG_BIT];
    end
  end

  // Shadow set: written by software, replaced by the ORed readback
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      shadow0_q <= `SDC_SHADOW0_RST;
      shadow1_q <= `SDC_SHADOW1_RST;
    end
    else if (done_now && !dir_q)
    begin
      shadow0_q <= acc_q[31:0];
      shadow1_q <= acc_q[63:32];
    end
    else if (reg_wr && reg_addr == `SDC_SHADOW0_ADDR)
      shadow0_q <= reg_wdata;
    else if (reg_wr && reg_addr == `SDC_SHADOW1_ADDR)
      shadow1_q <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata <= '0;
    else if (reg_rd)
      unique case (reg_addr)
        `SDC_FAST_CTRL_ADDR:
          reg_rdata <= {fast_rd_q, fast_wr_q, (30 - N_MACRO)'(0), fast_mask_q};
        `SDC_SLOW_CTRL_ADDR:
          reg_rdata <= {slow_rd_q, slow_wr_q, (30 - N_MACRO)'(0), slow_mask_q};
        `SDC_SHADOW0_ADDR: reg_rdata <= shadow0_q;
        `SDC_SHADOW1_ADDR: reg_rdata <= shadow1_q;
        `SDC_COEF_ADDR:
          reg_rdata <= {16'h0000, amp_coef, centre_tap_neg, 1'b0, centre_tap_coef};
        `SDC_STATUS_ADDR:
          reg_rdata <= {26'h000_0000, pcs_buf_ctrl, pcs_sigdet, dir_q, fam_q, state_q};
        default: reg_rdata <= '0;
      endcase
    else
      reg_rdata <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial configuration bus engine

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end
    else
    begin
      sdi_m_q <= cbus_sdi;
      sdi_s_q <= sdi_m_q;
    end
  end

  // Fast family wins when both families are pending
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= sdc_pkg::SDC_IDLE;
      fam_q <= 1'b0;
      dir_q <= 1'b0;
      mask_q <= '0;
      idx_q <= '0;
    end
    else
      unique case (state_q)
        sdc_pkg::SDC_IDLE:
        begin
          idx_q <= '0;
          if (fast_busy)
          begin
            fam_q <= 1'b0;
            dir_q <= fast_wr_q;
            mask_q <= fast_mask_q;
            state_q <= sdc_pkg::SDC_NEXT;
          end
          else if (slow_busy)
          begin
            fam_q <= 1'b1;
            dir_q <= slow_wr_q;
            mask_q <= slow_mask_q;
            state_q <= sdc_pkg::SDC_NEXT;
          end
        end
        sdc_pkg::SDC_NEXT:
        begin
          if (idx_q == IDX_END)
            state_q <= sdc_pkg::SDC_DONE;
          else if (mask_q[idx_q[2:0]])
            state_q <= sdc_pkg::SDC_SHIFT;
          else
            idx_q <= idx_q + 4'h1;
        end
        sdc_pkg::SDC_SHIFT:
        begin
          if (bit_tick && bit_q == `SDC_XFER_BITS - 7'h01)
          begin
            idx_q <= idx_q + 4'h1;
            state_q <= sdc_pkg::SDC_NEXT;
          end
        end
        sdc_pkg::SDC_DONE:
          state_q <= sdc_pkg::SDC_IDLE;
      endcase
  end

  // Bit timing and data shifting, one bit per CLK_DIV cycles
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      acc_q <= '0;
    end
    else if (state_q == sdc_pkg::SDC_IDLE)
    begin
      acc_q <= '0;
      div_q <= '0;
      bit_q <= '0;
    end
    else if (state_q == sdc_pkg::SDC_NEXT)
    begin
      div_q <= '0;
      bit_q <= '0;
      shift_q <= {shadow1_q, shadow0_q};
    end
    else if (state_q == sdc_pkg::SDC_SHIFT)
    begin
      div_q <= bit_tick ? 8'h00 : div_q + 8'h01;
      if (bit_tick)
      begin
        acc_q[bit_q[5:0]] <= acc_q[bit_q[5:0]] | sdi_s_q;
        shift_q <= {1'b0, shift_q[63:1]};
        bit_q <= bit_q + 7'h01;
      end
    end
  end

  // Selects fall back to zero between transfers so macros hold their setup
  always_comb
  begin
    fast_sel = '0;
    slow_sel = '0;
    if (state_q == sdc_pkg::SDC_SHIFT)
    begin
      if (fam_q)
        slow_sel[idx_q[2:0]] = 1'b1;
      else
        fast_sel[idx_q[2:0]] = 1'b1;
    end
  end

  assign cbus_dir = dir_q;
  assign cbus_sdo = shift_q[0];
  assign cbus_strobe = (state_q == sdc_pkg::SDC_SHIFT) && (div_q == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Signal detect with hysteresis

  logic sig_m_q;
  logic sig_s_q;
  logic [7:0] pre_q;
  logic unit_tick;
  logic [3:0] hcnt_q;
  logic hyst_en;
  logic [3:0] ast_time;
  logic [3:0] dst_time;
  logic [3:0] need_time;

  assign hyst_en = shadow1_q[`SDC_HYST_BIT];
  assign ast_time = shadow1_q[`SDC_AST_LSB +: 4];
  assign dst_time = shadow1_q[`SDC_DST_LSB +: 4];
  assign unit_tick = (pre_q == 8'(SIGDET_UNIT_CYC - 1));
  assign need_time = sig_s_q ? ast_time : dst_time;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sig_m_q <= 1'b0;
      sig_s_q <= 1'b0;
      pre_q <= '0;
    end
    else
    begin
      sig_m_q <= sigdet_raw;
      sig_s_q <= sig_m_q;
      pre_q <= unit_tick ? 8'h00 : pre_q + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pcs_sigdet <= 1'b0;
      hcnt_q <= '0;
    end
    else if (!hyst_en || sig_s_q == pcs_sigdet)
    begin
      pcs_sigdet <= sig_s_q;
      hcnt_q <= '0;
    end
    else if (unit_tick)
    begin
      if (hcnt_q + 4'h1 >= need_time)
      begin
        pcs_sigdet <= sig_s_q;
        hcnt_q <= '0;
      end
      else
        hcnt_q <= hcnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data inversion, low-power idle and tap coefficients

  logic lpi_both;
  logic [4:0] pre_tap;
  logic [5:0] post0_tap;
  logic [4:0] post1_tap;
  logic [6:0] side_sum;

  assign lpi_both = shadow1_q[`SDC_TXLPI_BIT] & shadow1_q[`SDC_RXLPI_BIT];
  assign pcs_buf_ctrl = lpi_both;
  assign pre_tap = shadow0_q[`SDC_PREC_LSB +: 5];
  assign post0_tap = shadow0_q[`SDC_POST0_LSB +: 6];
  assign post1_tap = shadow0_q[`SDC_POST1_LSB +: 5];
  assign side_sum = {3'h0, pre_tap[3:0]} + {2'h0, post0_tap[4:0]} + {3'h0, post1_tap[3:0]};

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_data_out <= '0;
      rx_data_out <= '0;
    end
    else
    begin
      tx_data_out <= tx_data_in ^ {DATA_W{shadow1_q[`SDC_TXINV_BIT]}};
      rx_data_out <= rx_data_in ^ {DATA_W{shadow1_q[`SDC_RXINV_BIT]}};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      obuf_idle <= 1'b0;
      ibuf_off <= 1'b0;
    end
    else
    begin
      obuf_idle <= lpi_both & pcs_tx_idle;
      ibuf_off <= lpi_both & pcs_rx_idle;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      centre_tap_coef <= `SDC_CENTRE_BASE;
      centre_tap_neg <= 1'b0;
      amp_coef <= `SDC_AMP_BASE;
    end
    else
    begin
      centre_tap_coef <= `SDC_CENTRE_BASE - side_sum;
      centre_tap_neg <= shadow0_q[`SDC_POL_BIT];
      amp_coef <= `SDC_AMP_BASE + {1'b0, shadow0_q[`SDC_LEV_LSB +: 6]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence seq_done_fast;
    state_q == sdc_pkg::SDC_DONE && !fam_q;
  endsequence

  AST_WR_CLEAR: assert property ($fell(fast_wr_q) |-> $past(state_q) == sdc_pkg::SDC_DONE)
    else $error("write trigger cleared outside done");
  AST_RD_CLEAR: assert property (seq_done_fast ##1 1'b1 |-> !fast_rd_q)
    else $error("read trigger not cleared after done");
  AST_SEL_MASK: assert property (fast_sel != '0 |-> $onehot(fast_sel) && (fast_sel & ~mask_q) == '0)
    else $error("select outside mask");
  AST_OR_MERGE: assert property (done_now && !dir_q |=> shadow0_q == $past(acc_q[31:0]))
    else $error("readback not loaded into shadow");
  AST_NO_HYST: assert property (!hyst_en |=> pcs_sigdet == $past(sig_s_q))
    else $error("signal detect not forwarded");
  AST_ASSERT_TIME: assert property ($rose(pcs_sigdet) && $past(hyst_en) |-> $past(unit_tick))
    else $error("signal detect asserted early");
  AST_DEASSERT_TIME: assert property ($fell(pcs_sigdet) && $past(hyst_en) |-> $past(hcnt_q) + 4'h1 >= $past(dst_time))
    else $error("signal detect deasserted early");
  AST_TX_INV: assert property (shadow1_q[`SDC_TXINV_BIT] ##1 $stable(tx_data_in) |-> tx_data_out == ~tx_data_in)
    else $error("transmit inversion wrong");
  AST_LPI: assert property (!lpi_both |=> !obuf_idle && !ibuf_off)
    else $error("buffers idled without low power mode");
  AST_CENTRE: assert property ($stable(shadow0_q) |-> centre_tap_coef + side_sum == `SDC_CENTRE_BASE)
    else $error("centre tap wrong");

endmodule

// >>> src/sdc_consts.svh
// Constants for the SerDes configuration bus controller
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
`define SDC_FAST_CTRL_ADDR 6'h00
`define SDC_SLOW_CTRL_ADDR 6'h04
`define SDC_SHADOW0_ADDR 6'h08
`define SDC_SHADOW1_ADDR 6'h0C
`define SDC_COEF_ADDR 6'h10
`define SDC_STATUS_ADDR 6'h14
`define SDC_WR_TRIG_BIT 30
`define SDC_RD_TRIG_BIT 31
`define SDC_PREC_LSB 0
`define SDC_POST0_LSB 5
`define SDC_POST1_LSB 11
`define SDC_POL_BIT 16
`define SDC_LEV_LSB 17
`define SDC_TXINV_BIT 0
`define SDC_RXINV_BIT 1
`define SDC_TXLPI_BIT 2
`define SDC_RXLPI_BIT 3
`define SDC_FXCR_BIT 4
`define SDC_IBFX_BIT 5
`define SDC_CPMD_LSB 6
`define SDC_HYST_BIT 8
`define SDC_AST_LSB 12
`define SDC_DST_LSB 16
`define SDC_SHADOW0_RST 32'h0001_0000
`define SDC_SHADOW1_RST 32'h0000_0000
`define SDC_XFER_BITS 7'h40
`define SDC_CENTRE_BASE 7'h40
`define SDC_AMP_BASE 7'h40
`define SDC_CLK_NS 100
`define SDC_SIGDET_UNIT_NS 1000
`endif

// >>> src/sdc_pkg.sv
// Types for the SerDes configuration bus controller
package sdc_pkg;
  typedef enum logic [1:0]
  {
    SDC_IDLE = 2'h0,
    SDC_NEXT = 2'h1,
    SDC_SHIFT = 2'h3,
    SDC_DONE = 2'h2
  } sdc_state_t;
endpackage

// >>> bench/sdc_macro_model.sv
// Behavioural model of one family of macros on the serial configuration bus
`timescale 1ns/100ps
module sdc_macro_model
#(
  parameter int N_MACRO = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N_MACRO-1:0] sel,
  input wire logic dir,
  input wire logic strobe,
  input wire logic sdo,
  output logic sdi
);
  logic [63:0] cfg_q [N_MACRO];
  logic [5:0] bit_q;
  logic last_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rst_b || sel == '0)
      bit_q <= 6'h00;
    else if (strobe)
      bit_q <= bit_q + 6'h01;
  end
  // Shift in written bits, keep them until the next write
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < N_MACRO; i++)
      if (!rst_b)
        cfg_q[i] <= 64'h0;
      else if (sel[i] && dir && strobe)
        cfg_q[i][bit_q] <= sdo;
  end
  // Read data; unselected line shows the inverse of its last level
  always_comb
  begin
    sdi = ~last_q;
    for (int i = 0; i < N_MACRO; i++)
      if (sel[i] && !dir)
        sdi = cfg_q[i][strobe ? bit_q : bit_q - 6'h01];
  end
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      last_q <= 1'b0;
    else
      last_q <= sdi;
  end
endmodule

// >>> bench/sdc_ctrl_tb_top.sv
// Self-checking testbench for the SerDes configuration bus controller
`timescale 1ns/100ps
`include "sdc_consts.svh"
module sdc_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] fast_sel, slow_sel;
  logic cbus_dir, cbus_strobe, cbus_sdo, cbus_sdi, sdi_f, sdi_s;
  logic sigdet_raw = 1'b0;
  logic pcs_sigdet, pcs_buf_ctrl, obuf_idle, ibuf_off, centre_tap_neg;
  logic [9:0] tx_data_in = 10'h000;
  logic [9:0] rx_data_in = 10'h000;
  logic [9:0] tx_data_out, rx_data_out;
  logic pcs_tx_idle = 1'b0;
  logic pcs_rx_idle = 1'b0;
  logic [6:0] centre_tap_coef, amp_coef;
  int n_fail = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  assign cbus_sdi = (slow_sel != 8'h00) ? sdi_s : sdi_f;
  ////////////////////////////////////////////////////////////////////////////
  sdc_ctrl u_sdc_ctrl (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_sel(fast_sel),
    .slow_sel(slow_sel), .cbus_dir(cbus_dir), .cbus_strobe(cbus_strobe), .cbus_sdo(cbus_sdo),
    .cbus_sdi(cbus_sdi), .sigdet_raw(sigdet_raw), .pcs_sigdet(pcs_sigdet),
    .tx_data_in(tx_data_in), .tx_data_out(tx_data_out), .rx_data_in(rx_data_in),
    .rx_data_out(rx_data_out), .pcs_buf_ctrl(pcs_buf_ctrl), .pcs_tx_idle(pcs_tx_idle),
    .pcs_rx_idle(pcs_rx_idle), .obuf_idle(obuf_idle), .ibuf_off(ibuf_off),
    .centre_tap_coef(centre_tap_coef), .centre_tap_neg(centre_tap_neg), .amp_coef(amp_coef));
  sdc_macro_model u_fast (.clk(clk), .rst_b(rst_b), .sel(fast_sel), .dir(cbus_dir),
    .strobe(cbus_strobe), .sdo(cbus_sdo), .sdi(sdi_f));
  sdc_macro_model u_slow (.clk(clk), .rst_b(rst_b), .sel(slow_sel), .dir(cbus_dir),
    .strobe(cbus_strobe), .sdo(cbus_sdo), .sdi(sdi_s));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] d;
    int k;
    wr(a, v);
    d = 32'hC000_0000;
    k = 0;
    while (d[31:30] != 2'b00 && k < 2000)
    begin
      rd(a, d);
      k++;
    end
    chk(d[31:30], 2'b00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_coef(input logic [31:0] s0, input logic [6:0] c, input logic n,
    input logic [6:0] a);
    logic [31:0] d;
    wr(`SDC_SHADOW0_ADDR, s0);
    wait_cyc(3);
    rd(`SDC_SHADOW0_ADDR, d);
    chk(d, s0);
    chk(centre_tap_coef, c);
    chk(centre_tap_neg, n);
    chk(amp_coef, a);
    rd(`SDC_COEF_ADDR, d);
    chk(d, {16'h0, a, n, 1'b0, c});
  endtask
  task automatic t_xfer();
    logic [31:0] d, e;
    wr(`SDC_SHADOW0_ADDR, 32'h0001_2345);
    wr(`SDC_SHADOW1_ADDR, 32'h0000_00B0);
    xfer(`SDC_FAST_CTRL_ADDR, 32'h4000_0005);
    chk(u_fast.cfg_q[0], 64'h0000_00B0_0001_2345);
    chk(u_fast.cfg_q[2], 64'h0000_00B0_0001_2345);
    chk(u_fast.cfg_q[1], 64'h0);
    wr(`SDC_SHADOW0_ADDR, 32'h0001_0C0A);
    wr(`SDC_SHADOW1_ADDR, 32'h0000_0001);
    xfer(`SDC_FAST_CTRL_ADDR, 32'h4000_0002);
    chk(u_fast.cfg_q[1], 64'h0000_0001_0001_0C0A);
    chk(u_fast.cfg_q[0], 64'h0000_00B0_0001_2345);
    xfer(`SDC_FAST_CTRL_ADDR, 32'h8000_0003);
    rd(`SDC_SHADOW0_ADDR, d);
    rd(`SDC_SHADOW1_ADDR, e);
    chk({e, d}, 64'h0000_00B1_0001_2F4F);
    xfer(`SDC_SLOW_CTRL_ADDR, 32'h4000_0001);
    chk(u_slow.cfg_q[0], 64'h0000_00B1_0001_2F4F);
    chk(u_fast.cfg_q[1], 64'h0000_0001_0001_0C0A);
  endtask
  task automatic t_pins();
    wr(`SDC_SHADOW1_ADDR, 32'h0000_0001);
    tx_data_in <= 10'h155;
    rx_data_in <= 10'h0F0;
    wait_cyc(3);
    chk({tx_data_out, rx_data_out}, {10'h2AA, 10'h0F0});
    wr(`SDC_SHADOW1_ADDR, 32'h0000_0002);
    wait_cyc(3);
    chk({tx_data_out, rx_data_out}, {10'h155, 10'h30F});
    wr(`SDC_SHADOW1_ADDR, 32'h0000_000C);
    pcs_tx_idle <= 1'b1;
    wait_cyc(3);
    chk({pcs_buf_ctrl, obuf_idle, ibuf_off}, 3'b110);
    @(posedge clk);
    pcs_rx_idle <= 1'b1;
    wait_cyc(3);
    chk({pcs_buf_ctrl, obuf_idle, ibuf_off}, 3'b111);
    wr(`SDC_SHADOW1_ADDR, 32'h0000_0004);
    wait_cyc(3);
    chk({pcs_buf_ctrl, obuf_idle, ibuf_off}, 3'b000);
  endtask
  task automatic t_sigdet();
    logic seen;
    wr(`SDC_SHADOW1_ADDR, 32'h0000_0000);
    sigdet_raw <= 1'b1;
    wait_cyc(5);
    chk(pcs_sigdet, 1'b1);
    sigdet_raw <= 1'b0;
    wait_cyc(5);
    chk(pcs_sigdet, 1'b0);
    wr(`SDC_SHADOW1_ADDR, 32'h0003_5100);
    sigdet_raw <= 1'b1;
    wait_cyc(20);
    sigdet_raw <= 1'b0;
    seen = 1'b0;
    repeat (60)
    begin
      @(posedge clk);
      #1;
      seen = seen | pcs_sigdet;
    end
    chk(seen, 1'b0);
    sigdet_raw <= 1'b1;
    wait_cyc(30);
    chk(pcs_sigdet, 1'b0);
    wait_cyc(30);
    chk(pcs_sigdet, 1'b1);
    sigdet_raw <= 1'b0;
    wait_cyc(15);
    chk(pcs_sigdet, 1'b1);
    wait_cyc(25);
    chk(pcs_sigdet, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    logic [31:0] d;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wait_cyc(3);
    rd(`SDC_SHADOW0_ADDR, d);
    chk(d, `SDC_SHADOW0_RST);
    rd(`SDC_COEF_ADDR, d);
    chk(d, 32'h0000_8140);
    t_coef(32'h007E_FFFF, 7'h03, 1'b0, 7'h7F);
    t_coef(32'h0001_1945, 7'h2E, 1'b1, 7'h40);
    t_xfer();
    t_pins();
    t_sigdet();
    give_verdict();
  end
endmodule
